// *** adc_conversion_control.sv ***
// adc_conversion_control: control register, start sequencing, flags and interrupt of the converter
// How it works
// - enable bit off keeps converter shut down
// - done flag sticky until cleared
// - busy reads one during conversion
// - busy write starts only in source 00b
// - window flag sets on window match
// - justify bit picks right or left
// - timer 1 or 2 overflow starts
// - strobe rising edge starts conversion
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [7:0]       rdata,
    input  wire logic        timer1_overflow,
    input  wire logic        timer2_overflow,
    input  wire logic        external_convert_strobe,
    input  wire logic [11:0] core_data,
    input  wire logic        core_valid,
    output logic             core_power_on,
    output logic             core_start,
    output logic             core_burst,
    output logic             irq
);
    typedef struct packed {
        adc_ctrl_pkg::conv_state_type fsm;
        logic [4:0]  count;
        logic        conv_enable_bit;
        logic        burst_select;
        logic        conv_done_flag;
        logic        conv_busy_flag;
        logic        window_match_flag;
        logic        left_justify_select;
        logic [1:0]  start_source_select;
        logic [1:0]  repeat_count_field;
        logic [11:0] result;
        logic [11:0] window_lo;
        logic [11:0] window_hi;
        logic [1:0]  irq_enable;
        logic [7:0]  rdata;
        logic        start_pulse;
    } ctrl_state_type;

    ctrl_state_type state;
    ctrl_state_type next_state;
    logic           start;
    logic           sw_start;
    logic           finish;
    logic           in_window;
    logic [7:0]     high_byte;
    logic [7:0]     low_byte;
    logic [11:0]    sample;
    logic [7:0]     control;
    logic           idle_ready;

    // every check below runs on the one clock and sleeps through reset
    default clocking chk_clock @(posedge clk); endclocking
    default disable iff (!rstn);

    // software start only counts while source is the busy-bit write
    assign sw_start = wr && addr == adc_ctrl_pkg::adc_control_addr
                      && wdata[adc_ctrl_pkg::bit_busy];

    start_select u_start (
        .clk                     (clk),
        .rstn                    (rstn),
        .source                  (state.start_source_select),
        .sw_start                (sw_start),
        .timer1_overflow         (timer1_overflow),
        .timer2_overflow         (timer2_overflow),
        .external_convert_strobe (external_convert_strobe),
        .start                   (start)
    );

    result_format u_format (
        .data         (state.result),
        .left_justify (state.left_justify_select),
        .high_byte    (high_byte),
        .low_byte     (low_byte)
    );

    // a conversion ends when the core delivers data or the internal count runs out
    assign finish = state.fsm == adc_ctrl_pkg::st_conv
                    && (core_valid || state.count == adc_ctrl_pkg::conv_last);
    assign sample = core_valid ? core_data : state.result;
    assign in_window = sample >= state.window_lo && sample <= state.window_hi;
    // trigger can be taken this cycle and no register write disturbs it
    assign idle_ready = state.fsm == adc_ctrl_pkg::st_idle && state.conv_enable_bit && !wr;

    assign control = {state.conv_enable_bit, state.burst_select, state.conv_done_flag,
                      state.conv_busy_flag, state.window_match_flag,
                      state.left_justify_select, state.start_source_select};

    // sequencer, register writes and flag updates
    always_comb begin
        next_state = state;
        next_state.start_pulse = 1'b0;
        unique case (state.fsm)
            adc_ctrl_pkg::st_off: begin
                if (state.conv_enable_bit) begin
                    next_state.fsm = adc_ctrl_pkg::st_idle;
                end
            end
            adc_ctrl_pkg::st_idle: begin
                if (!state.conv_enable_bit) begin
                    next_state.fsm = adc_ctrl_pkg::st_off;
                end else if (start) begin
                    next_state.fsm = adc_ctrl_pkg::st_conv;
                    next_state.count = 5'h00;
                    next_state.start_pulse = 1'b1;
                end
            end
            adc_ctrl_pkg::st_conv: begin
                next_state.count = state.count + 5'h01;
                if (finish) begin
                    next_state.fsm = adc_ctrl_pkg::st_idle;
                end
            end
            default: next_state.fsm = adc_ctrl_pkg::st_off;
        endcase
        // software writes first, so hardware events below win over a clear
        if (wr) begin
            unique case (addr)
                adc_ctrl_pkg::adc_control_addr: begin
                    next_state.conv_enable_bit     = wdata[adc_ctrl_pkg::bit_enable];
                    next_state.burst_select        = wdata[adc_ctrl_pkg::bit_burst];
                    next_state.conv_done_flag      = wdata[adc_ctrl_pkg::bit_done];
                    next_state.window_match_flag   = wdata[adc_ctrl_pkg::bit_window];
                    next_state.left_justify_select = wdata[adc_ctrl_pkg::bit_ljust];
                    next_state.start_source_select = wdata[1:0];
                end
                adc_ctrl_pkg::irq_enable_addr: next_state.irq_enable = wdata[1:0];
                adc_ctrl_pkg::irq_clear_addr: begin
                    if (wdata[0]) next_state.conv_done_flag = 1'b0;
                    if (wdata[1]) next_state.window_match_flag = 1'b0;
                end
                adc_ctrl_pkg::window_low_addr:  next_state.window_lo = {4'h0, wdata};
                adc_ctrl_pkg::window_high_addr: next_state.window_hi = {4'h0, wdata};
                adc_ctrl_pkg::repeat_addr:      next_state.repeat_count_field = wdata[1:0];
                default: ;
            endcase
        end
        // busy follows the sequencer: set on start, cleared on finish
        if (next_state.start_pulse) begin
            next_state.conv_busy_flag = 1'b1;
        end else if (finish || state.fsm != adc_ctrl_pkg::st_conv) begin
            next_state.conv_busy_flag = 1'b0;
        end
        if (finish) begin
            next_state.result = sample;
            next_state.conv_done_flag = 1'b1;
            if (in_window) begin
                next_state.window_match_flag = 1'b1;
            end
        end
        // read data for the cycle after the read strobe
        next_state.rdata = 8'h00;
        if (rd) begin
            unique case (addr)
                adc_ctrl_pkg::adc_control_addr: next_state.rdata = control;
                adc_ctrl_pkg::result_high_addr: next_state.rdata = high_byte;
                adc_ctrl_pkg::result_low_addr:  next_state.rdata = low_byte;
                adc_ctrl_pkg::irq_status_addr:
                    next_state.rdata = {6'h00, state.window_match_flag, state.conv_done_flag};
                adc_ctrl_pkg::irq_enable_addr:  next_state.rdata = {6'h00, state.irq_enable};
                adc_ctrl_pkg::window_low_addr:  next_state.rdata = state.window_lo[7:0];
                adc_ctrl_pkg::window_high_addr: next_state.rdata = state.window_hi[7:0];
                adc_ctrl_pkg::repeat_addr:
                    next_state.rdata = {6'h00, state.repeat_count_field};
                default: next_state.rdata = 8'h00;
            endcase
        end
    end

    // all control bits reset to zero; window opens fully so any result matches
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state           <= '0;
            state.window_hi <= adc_ctrl_pkg::window_hi_reset;
        end else begin
            state <= next_state;
        end
    end

    assign rdata         = state.rdata;
    assign core_power_on = state.conv_enable_bit;
    assign core_start    = state.start_pulse;
    assign core_burst    = state.burst_select;
    assign irq = |(state.irq_enable & {state.window_match_flag, state.conv_done_flag});

    // named steps of one conversion, plus a strobe held high for two cycles
    sequence conv_begin;
        state.start_pulse;
    endsequence
    sequence conv_end;
        state.conv_done_flag && !state.conv_busy_flag;
    endsequence
    sequence conv_finish;
        finish;
    endsequence
    sequence strobe_held;
        external_convert_strobe ##1 external_convert_strobe;
    endsequence

    a_off_no_start: assert property (@(posedge clk) disable iff (!rstn)
        !state.conv_enable_bit |=> !state.start_pulse)
        else $error("conversion started while disabled");
    a_done_sticky: assert property (@(posedge clk) disable iff (!rstn)
        state.conv_done_flag && !wr |=> state.conv_done_flag)
        else $error("done flag dropped without a write");
    a_busy_follows: assert property (@(posedge clk) disable iff (!rstn)
        conv_begin |-> state.conv_busy_flag)
        else $error("busy low after start");
    a_write_start: assert property (@(posedge clk) disable iff (!rstn)
        sw_start && state.start_source_select != 2'b00 |=> !state.start_pulse)
        else $error("write started conversion in wrong mode");
    a_window_sets: assert property (@(posedge clk) disable iff (!rstn)
        finish && in_window |=> state.window_match_flag)
        else $error("window flag not set on match");
    a_left_just: assert property (@(posedge clk) disable iff (!rstn)
        state.left_justify_select |-> low_byte[3:0] == 4'h0)
        else $error("left justify low nibble not zero");
    a_timer_start: assert property (@(posedge clk) disable iff (!rstn)
        state.fsm == adc_ctrl_pkg::st_idle && state.conv_enable_bit && !wr
        && state.start_source_select == 2'b01 && timer1_overflow |=> state.start_pulse)
        else $error("timer 1 overflow did not start");
    a_busy_ends: assert property (@(posedge clk) disable iff (!rstn)
        conv_finish |=> conv_end)
        else $error("busy and done not swapped at end");
    a_burst_out: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == adc_ctrl_pkg::adc_control_addr |=> core_burst == $past(wdata[6]))
        else $error("burst select not applied");

    // start triggers: each source starts only on its own event
    a_timer2_start: assert property (
        idle_ready && state.start_source_select == 2'b11 && timer2_overflow
        |=> state.start_pulse)
        else $error("timer 2 overflow did not start");
    a_strobe_level: assert property (
        start && state.start_source_select == 2'b10
        |-> external_convert_strobe)
        else $error("strobe start without strobe high");
    a_strobe_held: assert property (
        strobe_held
        |-> !start || state.start_source_select != 2'b10)
        else $error("held strobe started twice");
    a_sw_start: assert property (
        state.fsm == adc_ctrl_pkg::st_idle && state.conv_enable_bit && sw_start
        && state.start_source_select == 2'b00 |=> state.start_pulse)
        else $error("busy write did not start");
    a_busy_zero_write: assert property (
        wr && addr == adc_ctrl_pkg::adc_control_addr && !wdata[adc_ctrl_pkg::bit_busy]
        && state.start_source_select == 2'b00 |=> !state.start_pulse)
        else $error("busy write of zero started");

    // sequencer and busy: one conversion at a time, bounded length
    a_busy_matches: assert property (
        state.conv_busy_flag
        == (state.fsm == adc_ctrl_pkg::st_conv))
        else $error("busy disagrees with sequencer");
    a_start_single: assert property (
        state.start_pulse
        |=> !state.start_pulse)
        else $error("start pulse longer than one cycle");
    a_no_restart: assert property (
        state.fsm == adc_ctrl_pkg::st_conv
        |=> !state.start_pulse)
        else $error("start accepted while busy");
    a_off_shutdown: assert property (
        !state.conv_enable_bit && state.fsm != adc_ctrl_pkg::st_conv
        |=> state.fsm == adc_ctrl_pkg::st_off)
        else $error("disabled converter not shut down");
    a_power_up: assert property (
        state.conv_enable_bit && state.fsm == adc_ctrl_pkg::st_off
        |=> state.fsm == adc_ctrl_pkg::st_idle)
        else $error("enabled converter not ready");
    a_count_bound: assert property (
        state.fsm == adc_ctrl_pkg::st_conv
        |-> state.count <= adc_ctrl_pkg::conv_last)
        else $error("conversion count overran");
    a_finish_idle: assert property (
        conv_finish
        |=> state.fsm == adc_ctrl_pkg::st_idle)
        else $error("sequencer not idle after finish");
    a_conv_bounded: assert property (
        conv_begin
        |-> ##[1:12] conv_end)
        else $error("conversion did not end in time");

    // sticky flags: hardware only sets, software clears (a control write can also set them)
    a_done_clear: assert property (
        wr && addr == adc_ctrl_pkg::irq_clear_addr && wdata[0] && !finish
        |=> !state.conv_done_flag)
        else $error("done flag not cleared");
    a_done_quiet: assert property (
        !state.conv_done_flag && !finish && !wr
        |=> !state.conv_done_flag)
        else $error("done flag set without conversion");
    a_window_hold: assert property (
        state.window_match_flag && !wr
        |=> state.window_match_flag)
        else $error("window flag dropped by hardware");
    a_window_quiet: assert property (
        !state.window_match_flag && !finish && !wr
        |=> !state.window_match_flag)
        else $error("window flag set without match");
    a_window_clear: assert property (
        wr && addr == adc_ctrl_pkg::irq_clear_addr && wdata[1] && !finish
        |=> !state.window_match_flag)
        else $error("window flag not cleared");

    // result layout, status read back and burst hold
    a_result_kept: assert property (
        conv_finish
        |=> state.result == $past(sample))
        else $error("result not stored at finish");
    a_right_just: assert property (
        !state.left_justify_select
        |-> high_byte[7:4] == 4'h0 && low_byte == state.result[7:0])
        else $error("right justify layout wrong");
    a_ljust_high: assert property (
        state.left_justify_select
        |-> high_byte == state.result[11:4])
        else $error("left justify high byte wrong");
    a_status_read: assert property (
        rd && addr == adc_ctrl_pkg::irq_status_addr
        |=> rdata == {6'h00, $past(state.window_match_flag), $past(state.conv_done_flag)})
        else $error("status read back wrong");
    a_burst_hold: assert property (
        !(wr && addr == adc_ctrl_pkg::adc_control_addr)
        |=> $stable(core_burst))
        else $error("burst select moved without a write");

    // interrupt line follows enabled flags
    a_irq_done: assert property (
        state.irq_enable[0] && state.conv_done_flag
        |-> irq)
        else $error("done interrupt missing");
    a_irq_window: assert property (
        state.irq_enable[1] && state.window_match_flag
        |-> irq)
        else $error("window interrupt missing");
endmodule : adc_conversion_control
`default_nettype wire

// *** adc_ctrl_pkg.sv ***
// package: register map, field positions, reset values and timing for the converter control
package adc_ctrl_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] adc_control_addr  = 8'hE8;
    localparam logic [7:0] result_high_addr  = 8'hE9;
    localparam logic [7:0] result_low_addr   = 8'hEA;
    localparam logic [7:0] irq_status_addr   = 8'hEB;
    localparam logic [7:0] irq_enable_addr   = 8'hEC;
    localparam logic [7:0] irq_clear_addr    = 8'hED;
    localparam logic [7:0] window_low_addr   = 8'hEE;
    localparam logic [7:0] window_high_addr  = 8'hEF;
    localparam logic [7:0] repeat_addr       = 8'hF0;
    // bit positions inside adc_control
    localparam int bit_enable   = 7;
    localparam int bit_burst    = 6;
    localparam int bit_done     = 5;
    localparam int bit_busy     = 4;
    localparam int bit_window   = 3;
    localparam int bit_ljust    = 2;
    // reset values
    localparam logic [7:0]  control_reset   = 8'h00;
    localparam logic [11:0] window_lo_reset = 12'h000;
    localparam logic [11:0] window_hi_reset = 12'hFFF;
    // conversion time as a count of clock cycles (12 cycles at 125 MHz is 96 ns)
    localparam int conv_time_ns     = 96;
    localparam int clk_period_ns    = 8;
    localparam int conv_cycles      = (conv_time_ns + clk_period_ns - 1) / clk_period_ns;
    localparam logic [4:0] conv_last = 5'(conv_cycles - 1);
    // start-of-conversion sources
    typedef enum logic [1:0] {
        src_write   = 2'b00,
        src_timer1  = 2'b01,
        src_strobe  = 2'b10,
        src_timer2  = 2'b11
    } start_source_type;
    // sequencer states
    typedef enum logic [1:0] {
        st_off  = 2'b00,
        st_idle = 2'b01,
        st_conv = 2'b10
    } conv_state_type;
endpackage : adc_ctrl_pkg

// *** conv_core_model.sv ***
// conv_core_model: behavioural converter core that answers start pulses
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
    input  wire logic        clk,
    input  wire logic        power_on,
    input  wire logic        start,
    input  wire logic [11:0] sample,
    input  wire logic [3:0]  delay,
    output logic [11:0]      data,
    output var logic         valid
);
    logic [3:0] cnt;

    initial begin
        cnt = 4'h0;
        valid = 1'b0;
    end
    // only a powered core converts; delay sets a prompt or a slow answer
    always @(posedge clk) begin
        valid <= 1'b0;
        if (start && power_on) begin
            cnt <= delay;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            valid <= (cnt == 4'h1);
        end
    end
    // off the valid pulse the data lines show the inverse, never a stale value
    assign data = valid ? sample : ~sample;
endmodule : conv_core_model
`default_nettype wire

// *** result_format.sv ***
// result_format: justifies the 12-bit result into high and low bytes
`timescale 1ns/1ps
`default_nettype none
module result_format (
    input  wire logic [11:0] data,
    input  wire logic        left_justify,
    output logic [7:0]       high_byte,
    output logic [7:0]       low_byte
);
    // left: data in bits 15:4, right: data in bits 11:0
    always_comb begin
        if (left_justify) begin
            high_byte = data[11:4];
            low_byte  = {data[3:0], 4'h0};
        end else begin
            high_byte = {4'h0, data[11:8]};
            low_byte  = data[7:0];
        end
    end
endmodule : result_format
`default_nettype wire

// *** start_select.sv ***
// start_select: picks the start-of-conversion trigger and catches strobe rising edges
`timescale 1ns/1ps
`default_nettype none
module start_select (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [1:0] source,
    input  wire logic       sw_start,
    input  wire logic       timer1_overflow,
    input  wire logic       timer2_overflow,
    input  wire logic       external_convert_strobe,
    output logic            start
);
    typedef struct packed {
        logic strobe_last;
    } sel_state_type;

    sel_state_type state;
    sel_state_type next_state;

    // remember the strobe level so a held-high strobe starts only once
    always_comb begin
        next_state = state;
        next_state.strobe_last = external_convert_strobe;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // one-cycle trigger from the selected source
    always_comb begin
        unique case (adc_ctrl_pkg::start_source_type'(source))
            adc_ctrl_pkg::src_write:  start = sw_start;
            adc_ctrl_pkg::src_timer1: start = timer1_overflow;
            adc_ctrl_pkg::src_strobe: start = external_convert_strobe & ~state.strobe_last;
            adc_ctrl_pkg::src_timer2: start = timer2_overflow;
        endcase
    end
endmodule : start_select
`default_nettype wire

// *** testbench.sv ***
// testbench: random and corner-case checks of the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        tmr1 = 1'b0;
    logic        tmr2 = 1'b0;
    logic        strobe = 1'b0;
    logic [7:0]  rdata;
    logic [11:0] core_data;
    logic        core_valid;
    logic        power_on;
    logic        core_start;
    logic        burst;
    logic        irq;
    logic [11:0] sample = 12'h000;
    logic [3:0]  delay = 4'h1;
    logic [11:0] win_lo = 12'h000;
    logic [11:0] win_hi = 12'hFFF;
    logic [7:0]  rv;
    int          seed = 32'h3391;
    int          bad_count = 0;
    int          n_checks = 0;
    int          starts = 0;
    int          exp_starts = 0;

    always #4 clk = ~clk;
    // every start pulse is counted so a missed or extra start shows
    always @(posedge clk) if (core_start) starts++;

    adc_conversion_control i_dut (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .timer1_overflow(tmr1), .timer2_overflow(tmr2),
        .external_convert_strobe(strobe), .core_data(core_data),
        .core_valid(core_valid), .core_power_on(power_on),
        .core_start(core_start), .core_burst(burst), .irq(irq)
    );
    conv_core_model i_core (
        .clk(clk), .power_on(power_on), .start(core_start), .sample(sample),
        .delay(delay), .data(core_data), .valid(core_valid)
    );

    function automatic logic [15:0] exp_res(input logic [11:0] d, input logic lj);
        return lj ? {d, 4'h0} : {4'h0, d};
    endfunction : exp_res

    function automatic logic in_win(input logic [11:0] d);
        return (d >= win_lo) && (d <= win_hi);
    endfunction : in_win

    task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_reg

    task automatic chk_pin(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : chk_pin

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // fire the trigger that belongs to one start source
    task automatic kick(input logic [1:0] src, input logic [7:0] cfg);
        if (src == 2'b00) begin
            wr_reg(8'hE8, cfg | 8'h10);
        end else begin
            @(posedge clk);
            tmr1   <= (src == 2'b01);
            tmr2   <= (src == 2'b11);
            strobe <= (src == 2'b10);
            @(posedge clk);
            {tmr1, tmr2, strobe} <= 3'b000;
        end
    endtask : kick

    // one conversion: all foreign triggers first, then the selected one
    task automatic convert(input logic [1:0] src, input logic lj, input logic [11:0] d);
        logic [7:0] cfg;
        logic [7:0] v;
        cfg = 8'h80 | {5'h00, lj, src};
        sample = d;
        delay = 4'(1 + {$random(seed)} % 8);
        wr_reg(8'hE8, cfg);
        for (int s = 0; s < 4; s++)
            if (2'(s) != src) kick(2'(s), cfg);
        repeat (3) @(posedge clk);
        chk_reg("foreign start", 8'(exp_starts), 8'(starts));
        kick(src, cfg);
        exp_starts++;
        rd_reg(8'hE8, v);
        chk_reg("busy", cfg | 8'h10, v);
        v = 8'h00;
        for (int i = 0; i < 20 && v[5] !== 1'b1; i++) rd_reg(8'hE8, v);
        chk_reg("done", cfg | 8'h20 | {4'h0, in_win(d), 3'h0}, v);
        rd_reg(8'hE9, v);
        chk_reg("result high", exp_res(d, lj)[15:8], v);
        rd_reg(8'hEA, v);
        chk_reg("result low", exp_res(d, lj)[7:0], v);
    endtask : convert

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // watchdog: the whole sequence needs well under a tenth of this span
    initial begin
        #400000;
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(8'hE8, rv);
        chk_reg("control reset", 8'h00, rv);
        chk_pin("power off", 1'b0, power_on);
        wr_reg(8'hE8, 8'h10);
        repeat (4) @(posedge clk);
        chk_reg("start while off", 8'h00, 8'(starts));
        rd_reg(8'h00, rv);
        chk_reg("unmapped read", 8'h00, rv);
        wr_reg(8'hF0, 8'h00); // repeat count one; the field only reads back and gates nothing
        wr_reg(8'hE8, 8'hC0);
        repeat (2) @(posedge clk);
        chk_pin("power on", 1'b1, power_on);
        chk_pin("burst on", 1'b1, burst);
        wr_reg(8'hE8, 8'h80);
        repeat (2) @(posedge clk);
        chk_pin("burst off", 1'b0, burst);
        wr_reg(8'hEC, 8'h01);
        // every source with both justifications, full-range window
        for (int i = 0; i < 8; i++) convert(2'(i), i[2], 12'($random(seed)));
        chk_pin("irq raised", 1'b1, irq);
        wr_reg(8'hEC, 8'h00);
        chk_pin("irq masked", 1'b0, irq);
        wr_reg(8'hEC, 8'h01);
        rd_reg(8'hEB, rv);
        chk_reg("status done", 8'h03, rv);
        wr_reg(8'hED, 8'h01);
        chk_pin("irq cleared", 1'b0, irq);
        // narrow window, boundaries just inside and outside
        win_lo = 12'h010;
        win_hi = 12'h020;
        wr_reg(8'hEE, 8'h10);
        wr_reg(8'hEF, 8'h20);
        convert(2'b00, 1'b0, 12'h00F);
        convert(2'b10, 1'b0, 12'h021);
        convert(2'b11, 1'b1, 12'h020);
        convert(2'b01, 1'b0, 12'h010);
        // a later miss must not clear the flag; only software does
        sample = 12'h800;
        kick(2'b01, 8'h81);
        exp_starts++;
        repeat (20) @(posedge clk);
        rd_reg(8'hE8, rv);
        chk_reg("window sticky", 8'hA9, rv);
        wr_reg(8'hEC, 8'h02);
        chk_pin("irq window", 1'b1, irq);
        wr_reg(8'hE8, 8'h81);
        rd_reg(8'hE8, rv);
        chk_reg("window cleared", 8'h81, rv);
        chk_pin("irq window off", 1'b0, irq);
        for (int i = 0; i < 24; i++)
            convert(2'($random(seed)), 1'($random(seed)), 12'($random(seed)));
        wr_reg(8'hE8, 8'h00);
        repeat (2) @(posedge clk);
        chk_pin("power down", 1'b0, power_on);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
